// *** pkg/pcc_pkg.sv ***
// Constants and types for the configuration space target of function 0
package pcc_pkg;

	// ------------------------------------------------------------------
	// Bus commands and cycle qualifiers
	// ------------------------------------------------------------------
	localparam logic [3:0] CMD_MEM_RD   = 4'h6;
	localparam logic [3:0] CMD_MEM_WR   = 4'h7;
	localparam logic [3:0] CMD_CFG_RD   = 4'ha;
	localparam logic [3:0] CMD_CFG_WR   = 4'hb;
	localparam logic [2:0] FUNC_SEL     = 3'h0;
	localparam logic [1:0] CFG_TYPE0    = 2'h0;

	// ------------------------------------------------------------------
	// Header byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFF_ID       = 8'h00;
	localparam logic [7:0] OFF_CMD_STAT = 8'h04;
	localparam logic [7:0] OFF_CLASS    = 8'h08;
	localparam logic [7:0] OFF_HDR      = 8'h0c;
	localparam logic [7:0] OFF_BAR0     = 8'h10;
	localparam logic [7:0] OFF_SUBSYS   = 8'h2c;
	localparam logic [7:0] OFF_INT      = 8'h3c;

	// ------------------------------------------------------------------
	// Field layouts and fixed values
	// ------------------------------------------------------------------
	localparam logic [23:0] CLASS_CODE   = 24'h040000;
	localparam logic [7:0]  HDR_TYPE     = 8'h80;
	localparam logic [31:0] BAR_MEM_INFO = 32'h0000_0008;
	localparam logic [31:0] BAR_RW_MASK  = 32'hffff_f000;
	localparam logic [31:0] CMD_RW_MASK  = 32'h0000_0146;
	localparam logic [31:0] LAT_RW_MASK  = 32'h0000_f800;
	localparam logic [31:0] SSID_RW_MASK = 32'hffff_ffff;
	localparam logic [31:0] INTL_RW_MASK = 32'h0000_00ff;
	localparam logic [7:0]  STAT_RR_MASK = 8'hf9;
	localparam logic [7:0]  STAT_RO_HI   = 8'h02;
	localparam logic [7:0]  STAT_RO_LO   = 8'h80;
	localparam int          CMD_MEM_BIT  = 1;
	localparam int          CMD_MST_BIT  = 2;
	localparam int          CMD_PERR_BIT = 6;
	localparam int          CMD_SERR_BIT = 8;

	// ------------------------------------------------------------------
	// Types
	// ------------------------------------------------------------------
	typedef enum logic [1:0] {PCC_IDLE, PCC_DECODE, PCC_DATA, PCC_TURN} pcc_state_t;

	typedef struct packed {
		logic dpe;
		logic sse;
		logic rma;
		logic rta;
		logic sta;
		logic dpr;
	} pcc_evt_t;

	typedef struct packed {
		pcc_state_t  st;
		logic        frame_q;
		logic [5:0]  dw;
		logic        wr;
		logic [31:0] rdata;
		logic        par;
		logic        par_drv;
		logic        par_chk;
		logic        par_exp;
		logic        mem_hit;
		logic [31:0] cmd;
		logic [7:0]  stat;
		logic [31:0] lat;
		logic [31:0] bar;
		logic [31:0] ssid;
		logic [31:0] intl;
	} pcc_regs_t;

	localparam pcc_regs_t REGS_RST = '{st: PCC_IDLE, frame_q: 1'b1, default: '0};

endpackage

// *** core/pcc_cfg_target.sv ***
// Configuration space target for function 0 of a multifunction video device
`timescale 1ns/1ps
`default_nettype none

module pcc_cfg_target #(
	parameter logic [15:0] VENDOR_ID = 16'h1234,
	parameter logic [15:0] DEVICE_ID = 16'h5678,
	parameter logic [7:0]  REV_ID    = 8'h00,
	parameter logic [7:0]  INT_PIN   = 8'h01,
	parameter logic [7:0]  MIN_GNT   = 8'h00,
	parameter logic [7:0]  MAX_LAT   = 8'h00
) (
	input  wire logic             clk_sys_i,
	input  wire logic             rst_b_i,
	input  wire logic             frame_b_i,
	input  wire logic             irdy_b_i,
	input  wire logic             idsel_i,
	input  wire logic [31:0]      ad_i,
	input  wire logic [3:0]       cbe_b_i,
	input  wire logic             par_i,
	input  wire pcc_pkg::pcc_evt_t evt_i,
	output logic      [31:0]      ad_o,
	output logic                  ad_oe_b_o,
	output logic                  par_o,
	output logic                  par_oe_b_o,
	output logic                  trdy_b_o,
	output logic                  trdy_oe_b_o,
	output logic                  devsel_b_o,
	output logic                  devsel_oe_b_o,
	output logic                  mem_space_en_o,
	output logic                  bus_master_en_o,
	output logic                  perr_resp_en_o,
	output logic                  serr_en_o,
	output logic      [7:0]       latency_timer_o,
	output logic      [31:0]      bar0_o,
	output logic      [7:0]       int_line_o,
	output logic                  mem_hit_o
);

	// ------------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------------
	if (INT_PIN > 8'h04) begin : g_bad_int_pin
		$error("INT_PIN must be 0 to 4");
	end

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Merge written bytes whose enables are low, then keep only writable bits
	function automatic logic [31:0] wr_mask(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be_b, input logic [31:0] msk);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (!be_b[i]) begin
				m[8*i +: 8] = wd[8*i +: 8];
			end
		end
		wr_mask = (old & ~msk) | (m & msk);
	endfunction

	function automatic logic [31:0] rd_word(input pcc_pkg::pcc_regs_t s, input logic [5:0] dw);
		rd_word = 32'h0000_0000;
		case ({dw, 2'b00})
			pcc_pkg::OFF_ID: begin
				rd_word = {DEVICE_ID, VENDOR_ID};
			end
			pcc_pkg::OFF_CMD_STAT: begin
				rd_word = {(s.stat & pcc_pkg::STAT_RR_MASK) | pcc_pkg::STAT_RO_HI,
					pcc_pkg::STAT_RO_LO, s.cmd[15:0]};
			end
			pcc_pkg::OFF_CLASS: begin
				rd_word = {pcc_pkg::CLASS_CODE, REV_ID};
			end
			pcc_pkg::OFF_HDR: begin
				rd_word = {8'h00, pcc_pkg::HDR_TYPE, s.lat[15:0]};
			end
			pcc_pkg::OFF_BAR0: begin
				rd_word = s.bar | pcc_pkg::BAR_MEM_INFO;
			end
			pcc_pkg::OFF_SUBSYS: begin
				rd_word = s.ssid;
			end
			pcc_pkg::OFF_INT: begin
				rd_word = {MAX_LAT, MIN_GNT, INT_PIN, s.intl[7:0]};
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	endfunction

	// ------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------
	pcc_pkg::pcc_regs_t r_ff;
	pcc_pkg::pcc_regs_t nxt_r;
	logic               addr_phase;
	logic               cfg_hit;
	logic               xfer;
	logic               ev_dpe;
	logic [7:0]         stat_set;
	logic [7:0]         stat_clr;

	always_comb begin
		nxt_r = r_ff;
		nxt_r.frame_q = frame_b_i;
		nxt_r.par_chk = 1'b0;
		nxt_r.par_drv = 1'b0;
		nxt_r.mem_hit = 1'b0;
		stat_clr = 8'h00;
		addr_phase = !frame_b_i && r_ff.frame_q && (r_ff.st == pcc_pkg::PCC_IDLE);
		// Function 0 of a type 0 cycle
		cfg_hit = addr_phase && idsel_i && (ad_i[1:0] == pcc_pkg::CFG_TYPE0) &&
			(ad_i[10:8] == pcc_pkg::FUNC_SEL) &&
			((cbe_b_i == pcc_pkg::CMD_CFG_RD) || (cbe_b_i == pcc_pkg::CMD_CFG_WR));
		xfer = (r_ff.st == pcc_pkg::PCC_DATA) && !irdy_b_i;
		// Parity of the previous address or write data phase arrives one clock late
		ev_dpe = evt_i.dpe || (r_ff.par_chk && (par_i != r_ff.par_exp));
		stat_set = {ev_dpe, evt_i.sse, evt_i.rma, evt_i.rta, evt_i.sta, 2'b00, evt_i.dpr};

		case (r_ff.st)
			pcc_pkg::PCC_IDLE: begin
				if (addr_phase) begin
					nxt_r.par_chk = 1'b1;
					nxt_r.par_exp = ^{ad_i, cbe_b_i};
				end
				// Memory space told apart by command
				if (addr_phase && r_ff.cmd[pcc_pkg::CMD_MEM_BIT] &&
					((cbe_b_i == pcc_pkg::CMD_MEM_RD) || (cbe_b_i == pcc_pkg::CMD_MEM_WR)) &&
					(ad_i[31:12] == r_ff.bar[31:12])) begin
					nxt_r.mem_hit = 1'b1;
				end
				if (cfg_hit) begin
					nxt_r.st = pcc_pkg::PCC_DECODE;
					nxt_r.dw = ad_i[7:2];
					nxt_r.wr = cbe_b_i[0];
				end
			end
			// Medium select timing: one wait clock before claiming
			pcc_pkg::PCC_DECODE: begin
				nxt_r.st = pcc_pkg::PCC_DATA;
				nxt_r.rdata = rd_word(r_ff, r_ff.dw);
			end
			pcc_pkg::PCC_DATA: begin
				nxt_r.par_drv = !r_ff.wr;
				nxt_r.par = ^{r_ff.rdata, cbe_b_i};
				if (xfer) begin
					if (r_ff.wr) begin
						nxt_r.par_chk = 1'b1;
						nxt_r.par_exp = ^{ad_i, cbe_b_i};
						case ({r_ff.dw, 2'b00})
							pcc_pkg::OFF_CMD_STAT: begin
								nxt_r.cmd = wr_mask(r_ff.cmd, ad_i, cbe_b_i,
									pcc_pkg::CMD_RW_MASK);
								if (!cbe_b_i[3]) begin
									stat_clr = ad_i[31:24] & pcc_pkg::STAT_RR_MASK;
								end
							end
							pcc_pkg::OFF_HDR: begin
								nxt_r.lat = wr_mask(r_ff.lat, ad_i, cbe_b_i,
									pcc_pkg::LAT_RW_MASK);
							end
							pcc_pkg::OFF_BAR0: begin
								nxt_r.bar = wr_mask(r_ff.bar, ad_i, cbe_b_i,
									pcc_pkg::BAR_RW_MASK);
							end
							pcc_pkg::OFF_SUBSYS: begin
								nxt_r.ssid = wr_mask(r_ff.ssid, ad_i, cbe_b_i,
									pcc_pkg::SSID_RW_MASK);
							end
							pcc_pkg::OFF_INT: begin
								nxt_r.intl = wr_mask(r_ff.intl, ad_i, cbe_b_i,
									pcc_pkg::INTL_RW_MASK);
							end
							default: begin
								nxt_r.cmd = r_ff.cmd;
							end
						endcase
					end
					nxt_r.dw = r_ff.dw + 6'h01;
					nxt_r.rdata = rd_word(r_ff, r_ff.dw + 6'h01);
					if (frame_b_i) begin
						nxt_r.st = pcc_pkg::PCC_TURN;
					end
				end
			end
			pcc_pkg::PCC_TURN: begin
				nxt_r.st = pcc_pkg::PCC_IDLE;
			end
			default: begin
				nxt_r.st = pcc_pkg::PCC_IDLE;
			end
		endcase

		nxt_r.stat = ((r_ff.stat & ~stat_clr) | stat_set) & pcc_pkg::STAT_RR_MASK;
	end

	always_ff @(posedge clk_sys_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			r_ff <= pcc_pkg::REGS_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// ------------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------------
	// Strobes are driven high for one clock before release to avoid a slow float
	assign devsel_b_o      = (r_ff.st != pcc_pkg::PCC_DATA);
	assign trdy_b_o        = (r_ff.st != pcc_pkg::PCC_DATA);
	assign devsel_oe_b_o   = !((r_ff.st == pcc_pkg::PCC_DATA) || (r_ff.st == pcc_pkg::PCC_TURN));
	assign trdy_oe_b_o     = devsel_oe_b_o;
	assign ad_o            = r_ff.rdata;
	assign ad_oe_b_o       = !((r_ff.st == pcc_pkg::PCC_DATA) && !r_ff.wr);
	assign par_o           = r_ff.par;
	assign par_oe_b_o      = !r_ff.par_drv;
	assign mem_space_en_o  = r_ff.cmd[pcc_pkg::CMD_MEM_BIT];
	assign bus_master_en_o = r_ff.cmd[pcc_pkg::CMD_MST_BIT];
	assign perr_resp_en_o  = r_ff.cmd[pcc_pkg::CMD_PERR_BIT];
	assign serr_en_o       = r_ff.cmd[pcc_pkg::CMD_SERR_BIT];
	assign latency_timer_o = r_ff.lat[15:8];
	assign bar0_o          = r_ff.bar | pcc_pkg::BAR_MEM_INFO;
	assign int_line_o      = r_ff.intl[7:0];
	assign mem_hit_o       = r_ff.mem_hit;

endmodule

`default_nettype wire

// *** tb/pcc_host_model.sv ***
// Host bridge model issuing configuration and memory cycles
`timescale 1ns/1ps
`default_nettype none
module pcc_host_model (
	input  wire logic        clk_i,
	input  wire logic        trdy_b_i,
	input  wire logic [31:0] ad_i,
	output logic             frame_b_o,
	output logic             irdy_b_o,
	output logic             idsel_o,
	output logic [31:0]      ad_o,
	output logic [3:0]       cbe_b_o,
	output logic             par_o
);
	initial begin
		{frame_b_o, irdy_b_o, idsel_o, cbe_b_o, par_o} = 8'hfe;
		ad_o = '0;
	end
	task automatic cyc(input logic [3:0] cmd, input logic sel, input logic [31:0] adr,
			input logic [3:0] be_b, input int n, input logic [3:0][31:0] wd,
			output logic [3:0][31:0] rd, output logic ok);
		int t;
		ok = 1'b1;
		@(posedge clk_i);
		frame_b_o <= 1'b0;
		idsel_o <= sel;
		ad_o <= adr;
		cbe_b_o <= cmd;
		@(posedge clk_i);
		for (int k = 0; k < n; k++) begin
			par_o <= (k == 0) ? ^{adr, cmd} : cmd[0] ? ^{wd[k-1], be_b} : ~par_o;
			frame_b_o <= (k == n - 1);
			irdy_b_o <= 1'b0;
			idsel_o <= 1'b0;
			cbe_b_o <= be_b;
			// Released lines show the inverse so a stale value never passes
			ad_o <= cmd[0] ? wd[k] : ~adr;
			t = 0;
			do begin
				@(posedge clk_i);
				t++;
			end while (trdy_b_i !== 1'b0 && t < 8);
			if (trdy_b_i !== 1'b0) ok = 1'b0;
			rd[k] = ad_i;
		end
		par_o <= cmd[0] ? ^{wd[n-1], be_b} : ~par_o;
		irdy_b_o <= 1'b1;
		cbe_b_o <= 4'hf;
		ad_o <= ~ad_i;
		repeat (2) @(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// *** tb/pcc_cfg_target_asserts.sv ***
// Port assertions for the configuration target
`timescale 1ns/1ps
`default_nettype none
module pcc_cfg_target_asserts (
	input wire logic        clk_sys_i, rst_b_i, frame_b_i, irdy_b_i, idsel_i,
	input wire logic [31:0] ad_i, bar0_o,
	input wire logic [3:0]  cbe_b_i,
	input wire logic        ad_oe_b_o, devsel_b_o, devsel_oe_b_o, mem_hit_o, mem_space_en_o,
	input wire logic [7:0]  latency_timer_o,
	input wire logic [31:0] ad_o,
	input wire logic        par_o, par_oe_b_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_b_i);
	a_claim_qual: assert property ($fell(devsel_b_o) |-> $past(idsel_i, 2) && $past(ad_i[1:0], 2) == 2'h0)
		else $error("claim without select or aligned address");
	a_func_zero: assert property ($fell(devsel_b_o) |-> $past(ad_i[10:8], 2) == 3'h0)
		else $error("claim of another function");
	a_cfg_only: assert property ($fell(devsel_b_o) |-> $past(cbe_b_i[3:1], 2) == 3'h5)
		else $error("claim of a non configuration cycle");
	a_read_drive: assert property ($fell(devsel_b_o) |-> ad_oe_b_o == $past(cbe_b_i[0], 2))
		else $error("data bus drive does not follow direction");
	a_burst_hold: assert property (!devsel_b_o && !irdy_b_i && !frame_b_i |=> !devsel_b_o)
		else $error("burst ended early");
	a_last_end: assert property (!devsel_b_o && !irdy_b_i && frame_b_i |=> devsel_b_o ##1 devsel_oe_b_o)
		else $error("last phase not closed");
	a_mem_gate: assert property (mem_hit_o |-> $past(mem_space_en_o) && $past(cbe_b_i[3:1]) == 3'h3)
		else $error("memory hit while disabled");
	a_lat_low: assert property (latency_timer_o[2:0] == 3'h0)
		else $error("latency low bits not zero");
	a_bar_low: assert property (bar0_o[11:0] == 12'h008)
		else $error("base address low bits changed");
	a_read_par: assert property (!par_oe_b_o |-> par_o == ^{$past(ad_o), $past(cbe_b_i)})
		else $error("read parity does not cover previous data phase");
	c_burst: cover property (!devsel_b_o && !irdy_b_i && !frame_b_i);
	c_read: cover property (!ad_oe_b_o);
	c_hit: cover property (mem_hit_o);
endmodule
`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the configuration target
`timescale 1ns/1ps
`default_nettype none
module testbench;
	// Identity values are arbitrary
	localparam logic [15:0] VID = 16'h4a5b, DID = 16'h3c7d;
	localparam logic [7:0]  REV = 8'h2e, IPN = 8'h01, MNG = 8'h11, MXL = 8'h22;
	logic clk_sys_i, rst_b_i, frame_b_i, irdy_b_i, idsel_i, par_h, par_o, par_oe_b_o, ok;
	logic ad_oe_b_o, trdy_b_o, trdy_oe_b_o, devsel_b_o, devsel_oe_b_o, mem_hit_o;
	logic mem_space_en_o, bus_master_en_o, perr_resp_en_o, serr_en_o;
	logic [31:0] ad_h, ad_o, bar0_o, mdl [16];
	logic [7:0] latency_timer_o, int_line_o;
	logic [3:0] cbe_b_i;
	logic [3:0][31:0] wd, rd;
	pcc_pkg::pcc_evt_t evt_i;
	int n_fail, n_checks, ticks, hits;
	wire logic [31:0] ad_i = ad_oe_b_o ? ad_h : ad_o;
	wire logic par_i = par_oe_b_o ? par_h : par_o;
	wire logic trdy_w = trdy_oe_b_o ? 1'b1 : trdy_b_o;
	pcc_cfg_target #(.VENDOR_ID(VID), .DEVICE_ID(DID), .REV_ID(REV), .INT_PIN(IPN),
		.MIN_GNT(MNG), .MAX_LAT(MXL)) pcc_cfg_target_i (.*);
	pcc_host_model pcc_host_model_i (.clk_i(clk_sys_i), .trdy_b_i(trdy_w), .ad_i(ad_i),
		.frame_b_o(frame_b_i), .irdy_b_o(irdy_b_i), .idsel_o(idsel_i), .ad_o(ad_h),
		.cbe_b_o(cbe_b_i), .par_o(par_h));
	function automatic logic [31:0] rw_mask(input int i);
		case (i)
			1: return pcc_pkg::CMD_RW_MASK;
			3: return pcc_pkg::LAT_RW_MASK;
			4: return pcc_pkg::BAR_RW_MASK;
			11: return pcc_pkg::SSID_RW_MASK;
			15: return pcc_pkg::INTL_RW_MASK;
			default: return '0;
		endcase
	endfunction
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic mdl_rst();
		foreach (mdl[i]) mdl[i] = '0;
		mdl[0] = {DID, VID};
		mdl[1] = {pcc_pkg::STAT_RO_HI, pcc_pkg::STAT_RO_LO, 16'h0};
		mdl[2] = {pcc_pkg::CLASS_CODE, REV};
		mdl[3] = {8'h00, pcc_pkg::HDR_TYPE, 16'h0};
		mdl[4] = pcc_pkg::BAR_MEM_INFO;
		mdl[15] = {MXL, MNG, IPN, 8'h00};
	endtask
	task automatic acc(input logic [3:0] cmd, input logic sel, input logic [31:0] adr,
			input logic [3:0] be, input int n, input logic exp_ok);
		pcc_host_model_i.cyc(cmd, sel, adr, be, n, wd, rd, ok);
		chk(32'(ok), 32'(exp_ok));
	endtask
	task automatic wr(input int i, input logic [3:0] be, input int n);
		logic [31:0] m;
		acc(pcc_pkg::CMD_CFG_WR, 1'b1, 32'(i) << 2, be, n, 1'b1);
		for (int k = 0; k < n; k++) begin
			m = rw_mask(i + k) & {{8{~be[3]}}, {8{~be[2]}}, {8{~be[1]}}, {8{~be[0]}}};
			mdl[i+k] = (mdl[i+k] & ~m) | (wd[k] & m);
			if (i + k == 1 && !be[3]) mdl[1][31:24] &= ~(wd[k][31:24] & pcc_pkg::STAT_RR_MASK);
		end
	endtask
	task automatic rd_chk(input int i, input int n);
		acc(pcc_pkg::CMD_CFG_RD, 1'b1, 32'(i) << 2, 4'h0, n, 1'b1);
		for (int k = 0; k < n; k++) chk(rd[k], mdl[i+k]);
	endtask
	initial begin
		clk_sys_i = 1'b0;
		forever #2.5 clk_sys_i = ~clk_sys_i;
	end
	// Hang guard and memory hit counter
	always @(posedge clk_sys_i) begin
		ticks++;
		if (mem_hit_o === 1'b1) hits++;
		if (ticks == 20000) begin
			n_fail++;
			close_out();
		end
	end
	initial begin
		rst_b_i = 1'b0;
		evt_i = '0;
		void'($urandom(32'h0e39cbfb));
		for (int r = 0; r < 2; r++) begin
			mdl_rst();
			repeat (12) @(posedge clk_sys_i);
			rst_b_i <= 1'b1;
			for (int i = 0; i < 16; i += 4) rd_chk(i, 4);
			$display("test reset values done");
			if (r == 1) close_out();
			for (int p = 0; p < 3; p++)
				for (int i = 0; i < 16; i += 4) begin
					for (int k = 0; k < 4; k++) wd[k] = $urandom();
					wr(i, 4'($urandom()), 4);
					rd_chk(i, 4);
				end
			chk({mem_space_en_o, bus_master_en_o, perr_resp_en_o, serr_en_o},
				{mdl[1][1], mdl[1][2], mdl[1][6], mdl[1][8]});
			chk({latency_timer_o, int_line_o}, {mdl[3][15:8], mdl[15][7:0]});
			chk(bar0_o, mdl[4]);
			$display("test random access done");
			@(posedge clk_sys_i);
			evt_i <= pcc_pkg::pcc_evt_t'(6'($urandom()));
			@(posedge clk_sys_i);
			mdl[1][31:24] |= {evt_i[5:1], 2'b00, evt_i[0]};
			evt_i <= '0;
			rd_chk(1, 1);
			wd[0] = $urandom();
			wr(1, 4'h7, 1);
			rd_chk(1, 1);
			$display("test status clear done");
			wd[0] = '1;
			for (int c = 0; c < 3; c++)
				acc(pcc_pkg::CMD_CFG_WR, c != 0, c == 0 ? 32'h2c : c == 1 ? 32'h2d : 32'h12c,
					4'h0, 1, 1'b0);
			rd_chk(11, 1);
			wd[0] = 32'h8000_0000;
			wr(4, 4'h0, 1);
			for (int e = 0; e < 2; e++) begin
				hits = 0;
				wd[0] = 32'(e * 2);
				wr(1, 4'hc, 1);
				acc(pcc_pkg::CMD_MEM_RD, 1'b0, 32'h8000_0010, 4'h0, 1, 1'b0);
				chk(32'(hits), 32'(e));
			end
			$display("test decode done");
			rst_b_i <= 1'b0;
		end
	end
endmodule
bind pcc_cfg_target pcc_cfg_target_asserts pcc_cfg_target_asserts_i (.*);
`default_nettype wire
